// [core/lsc_split_cache.sv]
// Split instruction/data cache with entry locking, one cache side per bus.
// Assumes synchronous requests from the core and a word bus interface
// that acks each word of a read or write with a one-cycle pulse.
//
// Function
// - Both caches index and tag with physical addresses.
// - Lines consist of 4-byte sub-blocks, each with its own valid bit.
// - Miss refill is one word or four words, chosen by a setting.
// - Four-word refill is a bus burst; bus returns four consecutive words.
// - Instruction prefetch buffer fetches next sequential word ahead.
// - Unlocked two-way sets replace by least-recently-used way.
// - One global lock bit per cache locks the whole cache.
// - Globally locked cache never replaces a valid entry.
// - Invalid entries still fill under global lock, without added cycles.
// - Each tag line has a software lock bit exempting it from replacement.
// - With auto-lock enabled, every location hit or filled is locked by hardware.
// - Unlocked data lines allocate on loads only; stores write through.
// - Write-through stores queue in a four-word write buffer.
// - Store hitting a locked data line stays in cache only.
// - Separate buses, each cache sustains one access per clock.
// - Largest configuration: 256 sets, two banks, 32-byte lines.
// - Smallest configuration: direct mapped, 64 sets, 16-byte lines.
// - Enable and global lock bits per cache reset to zero.
// - Separate auto-lock enable bit per cache, active high.
`timescale 1ns/1ps

module lsc_cache_side #(
    parameter bit IS_DATA = 1'b0,
    parameter int SETS = lsc_pkg::MAX_SETS,
    parameter int WAYS = lsc_pkg::MAX_WAYS,
    parameter int LINE_BYTES = lsc_pkg::MAX_LINE_BYTES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire lsc_pkg::lsc_ctl_t ctl,
    input wire lsc_pkg::lsc_lock_wr_t lockWr,
    // Core side
    input wire logic reqValid,
    input wire lsc_pkg::lsc_req_t req,
    output logic busy,
    output logic ack,
    output logic [31:0] rdata,
    // Bus side
    output lsc_pkg::lsc_bus_req_t busOut,
    input wire lsc_pkg::lsc_bus_rsp_t busIn,
    output logic wbEmpty
);
    localparam int WPL = LINE_BYTES / lsc_pkg::WORD_BYTES;
    localparam int IDX_W = $clog2(SETS);
    localparam int OFF_W = $clog2(LINE_BYTES);
    localparam int WSEL_W = $clog2(WPL);
    localparam int TAG_W = lsc_pkg::ADDR_W - IDX_W - OFF_W;
    localparam int WB_W = $clog2(lsc_pkg::WB_DEPTH) + 1;
    localparam logic [WB_W-1:0] WB_FULL = WB_W'(lsc_pkg::WB_DEPTH);
    localparam logic [1:0] BURST_LAST = 2'(lsc_pkg::BURST_WORDS - 1);

    // ----------------------------------------
    // Storage and state
    // ----------------------------------------
    logic [TAG_W-1:0] tag_q [WAYS][SETS];
    logic [WPL-1:0] valid_q [WAYS][SETS];
    logic [31:0] data_q [WAYS][SETS][WPL];
    logic [1:0] lock_q [SETS];
    logic [SETS-1:0] lru_q;
    lsc_pkg::lsc_state_t state_q;
    lsc_pkg::lsc_bus_op_t busOp_q;
    lsc_pkg::lsc_req_t cur_q;
    lsc_pkg::lsc_bus_req_t busOut_q;
    lsc_pkg::lsc_req_t wb_q [lsc_pkg::WB_DEPTH];
    logic [WB_W-2:0] wbHead_q, wbTail_q;
    logic [WB_W-1:0] wbCnt_q;
    logic [1:0] busCnt_q;
    logic alloc_q, way_q, busy_q, ack_q, wbEmpty_q;
    logic [31:0] rdata_q, pfAddr_q, pfData_q;
    logic pfValid_q;

    // ----------------------------------------
    // Lookup on physical address
    // ----------------------------------------
    lsc_pkg::lsc_req_t op;
    logic [31:0] opWordAddr, fillAddr, hitData;
    logic [IDX_W-1:0] lookIdx;
    logic [TAG_W-1:0] lookTag;
    logic [WSEL_W-1:0] lookWord, fillWord;
    logic [1:0] tagHit, wordHit, lineEmpty, lockedW;
    logic hitWay, victim, victimNew, canAlloc, enHit;

    // Current operation: incoming request when idle, held request when waiting
    assign op = (state_q == lsc_pkg::ST_IDLE) ? req : cur_q;
    assign opWordAddr = op.addr & lsc_pkg::WORD_ALIGN_MASK;
    assign lookIdx = op.addr[OFF_W +: IDX_W];
    assign lookTag = op.addr[lsc_pkg::ADDR_W-1 -: TAG_W];
    assign lookWord = op.addr[2 +: WSEL_W];
    assign lockedW = lock_q[lookIdx];

    // Per-way tag compare and sub-block valid check
    for (genvar w = 0; w < 2; w++) begin : g_way
        if (w < WAYS) begin : g_real
            assign tagHit[w] = (tag_q[w][lookIdx] == lookTag) && (|valid_q[w][lookIdx]);
            assign wordHit[w] = tagHit[w] && valid_q[w][lookIdx][lookWord];
            assign lineEmpty[w] = ~|valid_q[w][lookIdx];
        end else begin : g_pad
            assign tagHit[w] = 1'b0;
            assign wordHit[w] = 1'b0;
            assign lineEmpty[w] = 1'b0;
        end
    end

    assign hitWay = wordHit[1];
    assign enHit = ctl.enable && (|wordHit);
    assign hitData = data_q[hitWay][lookIdx][lookWord];

    // Victim choice: partial line, then empty way, then LRU unless locked
    always_comb
    begin
        victim = 1'b0;
        victimNew = 1'b1;
        canAlloc = 1'b1;
        if (|tagHit)
        begin
            victim = tagHit[1];
            victimNew = 1'b0;
        end
        else if (|lineEmpty)
            victim = !lineEmpty[0];
        else if (ctl.globalLock)
            canAlloc = 1'b0;
        else if (WAYS == 1)
            canAlloc = !lockedW[0];
        else if (!lockedW[lru_q[lookIdx]])
            victim = lru_q[lookIdx];
        else if (!lockedW[!lru_q[lookIdx]])
            victim = !lru_q[lookIdx];
        else
            canAlloc = 1'b0;
    end

    // ----------------------------------------
    // Operation decode
    // ----------------------------------------
    logic opValid, opStore, storeLocal, wbFull, storeDone, wbPush, cacheStoreWr;
    logic loadHit, busFree, loadGo, pfServe, fillStart, allocNow, allocEv;
    logic busAckFill, fillLast, fillWr, wordWr, autoLockEv, lruUpd, lruWay, alWay;
    logic writeStart, wbPop, pfStart, done;

    assign opValid = (state_q == lsc_pkg::ST_WAIT) || reqValid;
    assign opStore = IS_DATA && op.we;
    assign wbFull = (wbCnt_q == WB_FULL);
    assign storeLocal = opStore && enHit
        && (lockedW[hitWay] || ctl.globalLock || ctl.autoLock);
    assign storeDone = opValid && opStore && (storeLocal || !wbFull);
    assign wbPush = opValid && opStore && !storeLocal && !wbFull;
    assign cacheStoreWr = storeDone && enHit;
    assign loadHit = reqValid && (state_q == lsc_pkg::ST_IDLE) && !opStore && enHit;

    // Misses wait until the bus and write buffer are empty, keeping order
    assign busFree = (busOp_q == lsc_pkg::BUS_IDLE) && (wbCnt_q == '0);
    assign loadGo = (state_q == lsc_pkg::ST_WAIT) && !opStore && busFree;
    assign pfServe = loadGo && !IS_DATA && pfValid_q && (pfAddr_q == opWordAddr);
    assign fillStart = loadGo && !pfServe;
    assign allocNow = ctl.enable && canAlloc && (fillStart || pfServe);
    assign allocEv = allocNow && victimNew;

    // Refill word tracking
    assign busAckFill = busIn.ack && (busOp_q == lsc_pkg::BUS_FILL);
    assign fillAddr = busOut_q.addr + {28'h000_0000, busCnt_q, 2'b00};
    assign fillWord = fillAddr[2 +: WSEL_W];
    assign fillLast = busAckFill && (!busOut_q.burst || busCnt_q == BURST_LAST);
    assign fillWr = busAckFill && alloc_q;
    assign wordWr = cacheStoreWr || fillWr || (pfServe && allocNow);
    assign done = loadHit || storeDone || pfServe || fillLast;

    // Auto-lock and LRU bookkeeping only when the cache is enabled
    assign alWay = (loadHit || cacheStoreWr) ? hitWay : victim;
    assign autoLockEv = ctl.enable && ctl.autoLock
        && (loadHit || cacheStoreWr || allocNow);
    assign lruUpd = ctl.enable && (loadHit || cacheStoreWr || allocNow);
    assign lruWay = alWay;

    // Bus starts
    assign writeStart = (busOp_q == lsc_pkg::BUS_IDLE) && (wbCnt_q != '0);
    assign wbPop = busIn.ack && (busOp_q == lsc_pkg::BUS_WRITE);
    assign pfStart = fillLast && !IS_DATA && ctl.prefetchEn;

    // ----------------------------------------
    // Cache arrays
    // ----------------------------------------
    logic wrWay;
    logic [WSEL_W-1:0] wrWord;
    logic [31:0] wrData;
    logic [3:0] wrBe;
    logic [WPL-1:0] wrBit;

    // Select the source of the single word write port
    assign wrWay = cacheStoreWr ? hitWay : (fillWr ? way_q : victim);
    assign wrWord = fillWr ? fillWord : lookWord;
    assign wrData = cacheStoreWr ? op.wdata : (fillWr ? busIn.rdata : pfData_q);
    assign wrBe = cacheStoreWr ? op.be : lsc_pkg::BE_ALL;
    assign wrBit = WPL'(1) << wrWord;

    // Tags, sub-block valids, locks and LRU
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int s = 0; s < SETS; s++)
            begin
                for (int w = 0; w < WAYS; w++)
                    valid_q[w][s] <= '0;
                lock_q[s] <= 2'b00;
            end
            lru_q <= '0;
        end
        else
        begin
            if (allocEv)
            begin
                tag_q[victim][lookIdx] <= lookTag;
                valid_q[victim][lookIdx] <= pfServe ? wrBit : '0;
            end
            else if (wordWr)
                valid_q[wrWay][lookIdx] <= valid_q[wrWay][lookIdx] | wrBit;
            if (lockWr.wr)
                lock_q[lockWr.idx[IDX_W-1:0]][lockWr.way] <= lockWr.val;
            if (autoLockEv)
                lock_q[lookIdx][alWay] <= 1'b1;
            if (lruUpd && WAYS > 1)
                lru_q[lookIdx] <= !lruWay;
        end
    end

    // Word data with byte lanes
    always_ff @(posedge clk)
    begin
        for (int b = 0; b < 4; b++)
            if (wordWr && wrBe[b])
                data_q[wrWay][lookIdx][wrWord][8*b +: 8] <= wrData[8*b +: 8];
    end

    // ----------------------------------------
    // Write buffer
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wbHead_q <= '0;
            wbTail_q <= '0;
            wbCnt_q <= '0;
        end
        else
        begin
            if (wbPush)
            begin
                wb_q[wbTail_q] <= op;
                wbTail_q <= wbTail_q + 1'b1;
            end
            if (wbPop)
                wbHead_q <= wbHead_q + 1'b1;
            wbCnt_q <= wbCnt_q + WB_W'(wbPush) - WB_W'(wbPop);
        end
    end

    // ----------------------------------------
    // Request state and core answers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= lsc_pkg::ST_IDLE;
            cur_q <= '0;
            busy_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= lsc_pkg::DATA_RST;
            wbEmpty_q <= 1'b1;
        end
        else
        begin
            if (state_q == lsc_pkg::ST_IDLE && reqValid && !done)
            begin
                state_q <= lsc_pkg::ST_WAIT;
                cur_q <= req;
            end
            else if (state_q == lsc_pkg::ST_WAIT && done)
                state_q <= lsc_pkg::ST_IDLE;
            busy_q <= (state_q == lsc_pkg::ST_IDLE) ? (reqValid && !done) : !done;
            ack_q <= done;
            if (loadHit)
                rdata_q <= hitData;
            else if (pfServe)
                rdata_q <= pfData_q;
            else if (busAckFill && fillAddr == opWordAddr)
                rdata_q <= busIn.rdata;
            wbEmpty_q <= (wbCnt_q + WB_W'(wbPush) - WB_W'(wbPop)) == '0;
        end
    end

    // ----------------------------------------
    // Bus sequencer: write drain, refill, prefetch
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busOp_q <= lsc_pkg::BUS_IDLE;
            busOut_q <= lsc_pkg::BUS_RST;
            busCnt_q <= 2'b00;
            alloc_q <= 1'b0;
            way_q <= 1'b0;
            pfValid_q <= 1'b0;
            pfAddr_q <= lsc_pkg::DATA_RST;
            pfData_q <= lsc_pkg::DATA_RST;
        end
        else if (fillStart)
        begin
            busOp_q <= lsc_pkg::BUS_FILL;
            busOut_q <= '{1'b1, (ctl.burstFill && allocNow)
                ? (op.addr & lsc_pkg::BURST_ALIGN_MASK) : opWordAddr,
                ctl.burstFill && allocNow, 1'b0, lsc_pkg::BE_ALL, 32'h0000_0000};
            busCnt_q <= 2'b00;
            alloc_q <= allocNow;
            way_q <= victim;
        end
        else if (writeStart)
        begin
            busOp_q <= lsc_pkg::BUS_WRITE;
            busOut_q <= '{1'b1, wb_q[wbHead_q].addr & lsc_pkg::WORD_ALIGN_MASK, 1'b0,
                1'b1, wb_q[wbHead_q].be, wb_q[wbHead_q].wdata};
        end
        else if (pfStart)
        begin
            busOp_q <= lsc_pkg::BUS_PREF;
            busOut_q <= '{1'b1, fillAddr + lsc_pkg::WORD_STEP, 1'b0, 1'b0,
                lsc_pkg::BE_ALL, 32'h0000_0000};
            pfValid_q <= 1'b0;
        end
        else if (busIn.ack && busOp_q == lsc_pkg::BUS_PREF)
        begin
            busOp_q <= lsc_pkg::BUS_IDLE;
            busOut_q.req <= 1'b0;
            pfAddr_q <= busOut_q.addr;
            pfData_q <= busIn.rdata;
            pfValid_q <= 1'b1;
        end
        else if (fillLast || wbPop)
        begin
            busOp_q <= lsc_pkg::BUS_IDLE;
            busOut_q.req <= 1'b0;
        end
        else if (busAckFill)
            busCnt_q <= busCnt_q + 2'b01;
    end

    assign busy = busy_q;
    assign ack = ack_q;
    assign rdata = rdata_q;
    assign busOut = busOut_q;
    assign wbEmpty = wbEmpty_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_fill_end;
        fillLast && pfStart;
    endsequence
    sequence s_pref_issued;
        busOut.req && !busOut.burst && (busOp_q == lsc_pkg::BUS_PREF);
    endsequence

    a_hit_one_cycle: assert property (loadHit |=> ack && rdata == $past(hitData))
        else $error("load hit not answered next cycle");
    a_locked_store_local: assert property (storeDone && storeLocal |-> !wbPush ##1 ack)
        else $error("locked store reached write buffer");
    a_store_no_alloc: assert property (opValid && opStore |-> !allocEv)
        else $error("store allocated a line");
    a_wb_depth_bound: assert property ((wbCnt_q <= WB_FULL) && !(wbFull && wbPush))
        else $error("write buffer overflow");
    a_global_keep_valid: assert property (allocEv && ctl.globalLock |-> lineEmpty[victim])
        else $error("valid entry replaced under global lock");
    a_invalid_fill_free: assert property (fillStart && ctl.enable && !(|tagHit)
        && (|lineEmpty) |-> allocNow)
        else $error("invalid entry not filled");
    a_entry_lock_keep: assert property (allocEv |-> !lockedW[victim])
        else $error("locked entry replaced");
    a_auto_lock_set: assert property (autoLockEv |=> lock_q[$past(lookIdx)][$past(alWay)])
        else $error("auto-lock did not lock the entry");
    a_burst_four_words: assert property (fillStart && ctl.burstFill && allocNow
        |=> busOut.req && busOut.burst && busOut.addr[3:0] == 4'h0)
        else $error("burst refill not issued aligned");
    a_disabled_bypass: assert property (opValid && !ctl.enable |-> !allocEv && !lruUpd)
        else $error("disabled cache allocated or aged");
    a_prefetch_next: assert property (s_fill_end |=> s_pref_issued
        and (busOut.addr == $past(fillAddr) + lsc_pkg::WORD_STEP))
        else $error("prefetch not issued to next word");
    a_lru_victim: assert property (allocEv && WAYS > 1 && !(|lineEmpty)
        && !lockedW[lru_q[lookIdx]] |-> victim == lru_q[lookIdx])
        else $error("victim is not the LRU way");
endmodule

`timescale 1ns/1ps

module lsc_split_cache #(
    parameter int I_SETS = lsc_pkg::MAX_SETS,
    parameter int I_WAYS = lsc_pkg::MAX_WAYS,
    parameter int I_LINE_BYTES = lsc_pkg::MAX_LINE_BYTES,
    parameter int D_SETS = lsc_pkg::MAX_SETS,
    parameter int D_WAYS = lsc_pkg::MAX_WAYS,
    parameter int D_LINE_BYTES = lsc_pkg::MAX_LINE_BYTES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control bits per cache
    input wire lsc_pkg::lsc_ctl_t icCtl,
    input wire lsc_pkg::lsc_ctl_t dcCtl,
    input wire lsc_pkg::lsc_lock_wr_t icLockWr,
    input wire lsc_pkg::lsc_lock_wr_t dcLockWr,
    // Instruction bus
    input wire logic iReqValid,
    input wire lsc_pkg::lsc_req_t iReq,
    output logic iBusy,
    output logic iAck,
    output logic [31:0] iRdata,
    // Data bus
    input wire logic dReqValid,
    input wire lsc_pkg::lsc_req_t dReq,
    output logic dBusy,
    output logic dAck,
    output logic [31:0] dRdata,
    // Bus interface unit ports
    output lsc_pkg::lsc_bus_req_t iBusOut,
    input wire lsc_pkg::lsc_bus_rsp_t iBusIn,
    output lsc_pkg::lsc_bus_req_t dBusOut,
    input wire lsc_pkg::lsc_bus_rsp_t dBusIn,
    output logic dWbEmpty
);
    lsc_pkg::lsc_ctl_t icCtl_q, dcCtl_q;

    // Control bits held in registers, cleared by reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            icCtl_q <= lsc_pkg::CTL_RST;
            dcCtl_q <= lsc_pkg::CTL_RST;
        end
        else
        begin
            icCtl_q <= icCtl;
            dcCtl_q <= dcCtl;
        end
    end

    // Instruction side, own bus
    lsc_cache_side #(.IS_DATA(1'b0), .SETS(I_SETS), .WAYS(I_WAYS),
        .LINE_BYTES(I_LINE_BYTES)) uInstr (
        .clk(clk), .rst_n(rst_n), .ctl(icCtl_q), .lockWr(icLockWr),
        .reqValid(iReqValid), .req(iReq), .busy(iBusy), .ack(iAck), .rdata(iRdata),
        .busOut(iBusOut), .busIn(iBusIn), .wbEmpty());

    // Data side, own bus
    lsc_cache_side #(.IS_DATA(1'b1), .SETS(D_SETS), .WAYS(D_WAYS),
        .LINE_BYTES(D_LINE_BYTES)) uData (
        .clk(clk), .rst_n(rst_n), .ctl(dcCtl_q), .lockWr(dcLockWr),
        .reqValid(dReqValid), .req(dReq), .busy(dBusy), .ack(dAck), .rdata(dRdata),
        .busOut(dBusOut), .busIn(dBusIn), .wbEmpty(dWbEmpty));
endmodule

// [shared/lsc_pkg.sv]
// Constants and carrier types for the lockable split cache.
// Assumes a 32-bit physical address and a 32-bit word bus.
package lsc_pkg;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int WORD_BYTES = 4;
    localparam int BURST_WORDS = 4;
    localparam int WB_DEPTH = 4;
    localparam int MAX_SETS = 256;
    localparam int MAX_WAYS = 2;
    localparam int MAX_LINE_BYTES = 32;
    localparam int MIN_SETS = 64;
    localparam int MIN_WAYS = 1;
    localparam int MIN_LINE_BYTES = 16;
    localparam int LOCK_IDX_W = 8;

    // ----------------------------------------
    // Address masks and reset values
    // ----------------------------------------
    localparam logic [31:0] BURST_ALIGN_MASK = 32'hFFFF_FFF0;
    localparam logic [31:0] WORD_ALIGN_MASK = 32'hFFFF_FFFC;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [3:0] BE_ALL = 4'hF;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic enable;
        logic globalLock;
        logic autoLock;
        logic burstFill;
        logic prefetchEn;
    } lsc_ctl_t;

    localparam lsc_ctl_t CTL_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic [31:0] addr;
        logic we;
        logic [3:0] be;
        logic [31:0] wdata;
    } lsc_req_t;

    typedef struct packed {
        logic req;
        logic [31:0] addr;
        logic burst;
        logic we;
        logic [3:0] be;
        logic [31:0] wdata;
    } lsc_bus_req_t;

    localparam lsc_bus_req_t BUS_RST = '{1'b0, 32'h0000_0000, 1'b0, 1'b0, 4'h0, 32'h0000_0000};

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } lsc_bus_rsp_t;

    typedef struct packed {
        logic wr;
        logic way;
        logic [7:0] idx;
        logic val;
    } lsc_lock_wr_t;

    typedef enum logic {ST_IDLE = 1'b0, ST_WAIT = 1'b1} lsc_state_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_FILL = 2'b10,
        BUS_PREF = 2'b11
    } lsc_bus_op_t;

endpackage

// [verification/lsc_bus_model.sv]
// Bus unit model for one cache side: random-latency word and burst acks.
// Assumes lsc_pkg; read data is a fixed pattern of the word address.
`timescale 1ns/1ps
module lsc_bus_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Cache side
    input wire lsc_pkg::lsc_bus_req_t busOut,
    output lsc_pkg::lsc_bus_rsp_t busIn,
    output int nWrites
);
    logic [1:0] beat_q;
    logic cool_q;
    logic [15:0] wa;

    // Address of the word in the current beat
    assign wa = busOut.addr[15:0] + {12'h000, beat_q, 2'h0};

    // One ack per word, four on a burst, idle cycle after the last
    always @(posedge clk)
    begin
        busIn.ack <= 1'b0;
        busIn.rdata <= ~busIn.rdata; // Idle data keeps changing
        if (!rst_n)
        begin
            beat_q <= 2'h0;
            cool_q <= 1'b0;
            nWrites <= 0;
            busIn.rdata <= 32'h0000_0000;
        end
        else if (cool_q)
            cool_q <= 1'b0;
        else if (busOut.req && $urandom_range(1, 0) == 1)
        begin
            busIn.ack <= 1'b1;
            busIn.rdata <= {wa, ~wa};
            beat_q <= beat_q + 2'h1;
            if (beat_q == {2{busOut.burst}})
            begin
                beat_q <= 2'h0;
                cool_q <= 1'b1;
                nWrites <= nWrites + int'(busOut.we);
            end
        end
    end
endmodule

// [verification/testbench.sv]
// Self-checking bench for the split cache with a bus model per side.
// Assumes lsc_pkg and the design and model modules are compiled first.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    lsc_pkg::lsc_ctl_t icCtl = lsc_pkg::CTL_RST;
    lsc_pkg::lsc_ctl_t dcCtl = lsc_pkg::CTL_RST;
    lsc_pkg::lsc_lock_wr_t noLock = '0;
    logic iReqValid = 1'b0;
    logic dReqValid = 1'b0;
    lsc_pkg::lsc_req_t iReq = '0;
    lsc_pkg::lsc_req_t dReq = '0;
    logic iBusy, iAck, dBusy, dAck, dWbEmpty;
    logic [31:0] iRdata, dRdata, b, wd;
    lsc_pkg::lsc_bus_req_t iBusOut, dBusOut;
    lsc_pkg::lsc_bus_rsp_t iBusIn, dBusIn;
    int iWr, dWr, w0, n_fail = 0, n_checks = 0;
    logic [32:0] qi[$], qd[$], e;

    always #50 clk = ~clk;

    lsc_split_cache dut (.clk(clk), .rst_n(rst_n), .icCtl(icCtl), .dcCtl(dcCtl),
        .icLockWr(noLock), .dcLockWr(noLock), .iReqValid(iReqValid), .iReq(iReq),
        .iBusy(iBusy), .iAck(iAck), .iRdata(iRdata), .dReqValid(dReqValid),
        .dReq(dReq), .dBusy(dBusy), .dAck(dAck), .dRdata(dRdata), .iBusOut(iBusOut),
        .iBusIn(iBusIn), .dBusOut(dBusOut), .dBusIn(dBusIn), .dWbEmpty(dWbEmpty));
    lsc_bus_model mi (.clk(clk), .rst_n(rst_n), .busOut(iBusOut), .busIn(iBusIn),
        .nWrites(iWr));
    lsc_bus_model md (.clk(clk), .rst_n(rst_n), .busOut(dBusOut), .busIn(dBusIn),
        .nWrites(dWr));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction

    // One request; lat>0 exact ack delay, lat<0 a miss, lat=0 unchecked
    task automatic acc(input bit isI, input logic [31:0] a, input bit we,
        input logic [31:0] d, input int lat);
        int n;
        if (isI)
            qi.push_back({!we, d});
        else
            qd.push_back({!we, d});
        @(negedge clk);
        iReqValid = isI;
        iReq = '{a, we, lsc_pkg::BE_ALL, d};
        dReqValid = !isI;
        dReq = '{a, we, lsc_pkg::BE_ALL, d};
        @(negedge clk);
        iReqValid = 1'b0;
        dReqValid = 1'b0;
        n = 1;
        while ((isI ? iAck : dAck) !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 300)
        begin
            n_fail++;
            give_verdict();
        end
        if (lat > 0)
            check(n, lat);
        else if (lat < 0)
            check(n > 1, 1);
    endtask

    task automatic drain;
        int n;
        repeat (2) @(negedge clk);
        for (n = 0; n < 300 && dWbEmpty !== 1'b1; n++)
            @(negedge clk);
        if (n >= 300)
        begin
            n_fail++;
            give_verdict();
        end
    endtask

    // Load results compared against the oldest note
    always @(negedge clk)
    begin
        if (dAck === 1'b1 && qd.size() > 0)
        begin
            e = qd.pop_front();
            if (e[32])
                check(dRdata, e[31:0]);
        end
        if (iAck === 1'b1 && qi.size() > 0)
        begin
            e = qi.pop_front();
            if (e[32])
                check(iRdata, e[31:0]);
        end
    end

    // Main sequence
    initial
    begin
        w0 = $urandom(32'h198d_b14a);
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        check({dBusOut.req, iBusOut.req, dBusy, iBusy, dWbEmpty}, 5'h01);
        b = $urandom & 32'h00ff_ffe0;
        wd = $urandom;
        dcCtl = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        repeat (3) @(negedge clk);
        acc(0, b, 0, pat(b), -1);
        acc(0, b + 32'h8, 0, pat(b + 32'h8), 1);
        acc(0, b + 32'hc, 0, pat(b + 32'hc), 1);
        w0 = dWr;
        acc(0, b + 32'h4, 1, wd, 1);
        drain();
        check(dWr - w0, 1);
        acc(0, b + 32'h4, 0, wd, 1);
        acc(0, b + 32'h1000, 1, wd, 0);
        acc(0, b + 32'h1000, 0, pat(b + 32'h1000), -1);
        dcCtl.globalLock = 1'b1;
        repeat (3) @(negedge clk);
        w0 = dWr;
        acc(0, b + 32'h4, 1, ~wd, 1);
        drain();
        check(dWr - w0, 0);
        acc(0, b + 32'h4, 0, ~wd, 1);
        acc(0, b + 32'h400, 0, pat(b + 32'h400), -1);
        acc(0, b + 32'h400, 0, pat(b + 32'h400), 1);
        dcCtl = lsc_pkg::CTL_RST;
        repeat (3) @(negedge clk);
        acc(0, b + 32'h4, 0, pat(b + 32'h4), -1);
        acc(0, b + 32'h4, 0, pat(b + 32'h4), -1);
        icCtl = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        repeat (3) @(negedge clk);
        acc(1, b, 0, pat(b), -1);
        acc(1, b, 0, pat(b), 1);
        repeat (20) @(negedge clk);
        acc(1, b + 32'h4, 0, pat(b + 32'h4), 2);
        give_verdict();
    end
endmodule
